// >>> rtl/tdc_top.sv
/*
 * Dual tamper control: two channels, config and flags registers, interrupt,
 * external clear and reset request, clock freeze, wiped 128-byte user ram.
 * Assumes a byte register port on sys_clk, an outside reset stretcher,
 * and on_battery / osc_running from on-chip logic.
 */
// Operation
// - two channels, each setting its own flag
// - channel configs at two separate addresses
// - enable arms detection; flag clears when zero
// - flag read-only, set by tamper, cleared by enable
// - interrupt enable lets tamper raise interrupt
// - battery needs alarm-in-backup enable
// - switch type picks normally open or closed
// - polarity bit sets tamper level high/low
// - closed type: 1 Hz sampling or continuous
// - open type always monitored continuously
// - sampling only while oscillator runs
// - pull strength bit, closed type only
// - internal wipe zeroes all user ram
// - ram deselected until enable written zero
// - external wipe: clear output, reset request
// - tamper reset equals other reset sources
// - two-bit field sets clear output width
// - high second tamper on an external-wipe channel ignored during clear
// - widths: 1, 4, 8, 16 seconds
// - first tamper freezes clock until both disabled
// - interrupt cleared by flags read, disable, reset
// - sampling: pull on one millisecond each second
`timescale 1ns/1ps
module tdc_top #(
    parameter int SECOND_CYCLES = tdc_pkg::SECOND_CYCLES,
    parameter int WINDOW_CYCLES = tdc_pkg::WINDOW_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic intrusion_input_one,
    input wire logic intrusion_input_two,
    input wire logic on_battery,
    input wire logic osc_running,
    input wire logic alarm_in_backup_enable,
    input wire logic clear_width_bit0,
    input wire logic clear_width_bit1,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    input wire logic [tdc_pkg::RAM_AW-1:0] ram_addr,
    input wire logic ram_wr_en,
    input wire logic [7:0] ram_wr_data,
    input wire logic ram_rd_en,
    output logic [7:0] ram_rd_data,
    output logic ram_deselect,
    output logic irq_active,
    output logic external_clear_output,
    output logic tamper_reset_req,
    output logic clock_freeze,
    output logic pull_enable_one,
    output logic pull_enable_two,
    output logic pull_strong_one,
    output logic pull_strong_two
);
    // configuration registers
    tdc_pkg::tdc_cfg_t cfg_one_ff;
    tdc_pkg::tdc_cfg_t cfg_two_ff;
    tdc_pkg::tdc_cfg_t nxt_cfg_one;
    tdc_pkg::tdc_cfg_t nxt_cfg_two;

    // output registers
    logic [7:0] rd_data_ff;
    logic [7:0] ram_rd_data_ff;
    logic irq_ff;
    logic reset_req_ff;
    logic freeze_ff;
    logic clear_out_ff;

    // second timer and sample window
    logic [tdc_pkg::TIMER_W-1:0] sec_cnt_ff;
    logic [tdc_pkg::TIMER_W-1:0] nxt_sec_cnt;
    logic window_ff;
    logic nxt_window;

    // ram, wipe sequencer and lock bits
    logic [7:0] ram_mem [tdc_pkg::RAM_DEPTH];
    tdc_pkg::tdc_wipe_state_t wipe_state_ff;
    tdc_pkg::tdc_wipe_state_t nxt_wipe_state;
    logic [tdc_pkg::RAM_AW-1:0] wipe_addr_ff;
    logic [1:0] lock_ff;
    logic [1:0] nxt_lock;

    // channel results
    logic [1:0] ev;
    logic [1:0] flag;
    logic [1:0] det_en;
    logic [1:0] irq_en;
    logic [1:0] int_wipe;
    logic [1:0] ext_wipe;
    logic clear_busy;
    logic pull_en_one;
    logic pull_en_two;
    logic pull_st_one;
    logic pull_st_two;

    // register port decode
    logic hit_flags;
    logic hit_cfg_one;
    logic hit_cfg_two;
    logic wr_cfg_one;
    logic wr_cfg_two;
    logic rd_flags;
    logic [7:0] flags_word;
    logic [7:0] nxt_rd_data;

    // event combining
    logic irq_allowed;
    logic irq_fire;
    logic irq_clear;
    logic nxt_irq;
    logic ext_fire;
    logic nxt_freeze;
    logic [1:0] clear_code;
    logic [4:0] clear_secs;
    logic [tdc_pkg::TIMER_W-1:0] clear_load;

    // ram access
    logic ram_blocked;
    logic ram_write;
    logic [7:0] nxt_ram_rd;

    assign det_en = {cfg_two_ff.detect_enable, cfg_one_ff.detect_enable};
    assign irq_en = {cfg_two_ff.irq_enable, cfg_one_ff.irq_enable};
    assign int_wipe = {cfg_two_ff.internal_wipe, cfg_one_ff.internal_wipe};
    assign ext_wipe = {cfg_two_ff.external_wipe, cfg_one_ff.external_wipe};

    // address decode, one register per channel
    assign hit_flags = (reg_addr == tdc_pkg::ADDR_FLAGS);
    assign hit_cfg_one = (reg_addr == tdc_pkg::ADDR_CFG_ONE);
    assign hit_cfg_two = (reg_addr == tdc_pkg::ADDR_CFG_TWO);
    assign wr_cfg_one = reg_wr_en & hit_cfg_one;
    assign wr_cfg_two = reg_wr_en & hit_cfg_two;
    assign rd_flags = reg_rd_en & hit_flags;

    // config writes; the flags register ignores writes
    assign nxt_cfg_one = wr_cfg_one ? tdc_pkg::tdc_cfg_t'(reg_wr_data) : cfg_one_ff;
    assign nxt_cfg_two = wr_cfg_two ? tdc_pkg::tdc_cfg_t'(reg_wr_data) : cfg_two_ff;

    always_comb begin
        flags_word = tdc_pkg::FLAGS_RESET;
        flags_word[tdc_pkg::FLAG_ONE_BIT] = flag[0];
        flags_word[tdc_pkg::FLAG_TWO_BIT] = flag[1];
    end

    // read mux; unmapped offsets read as zero
    assign nxt_rd_data = hit_flags ? flags_word :
                         hit_cfg_one ? 8'(cfg_one_ff) :
                         hit_cfg_two ? 8'(cfg_two_ff) :
                         tdc_pkg::UNMAPPED_DATA;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_one_ff <= tdc_pkg::tdc_cfg_t'(tdc_pkg::CFG_RESET);
            cfg_two_ff <= tdc_pkg::tdc_cfg_t'(tdc_pkg::CFG_RESET);
            rd_data_ff <= tdc_pkg::UNMAPPED_DATA;
        end else if (clk_en) begin
            cfg_one_ff <= nxt_cfg_one;
            cfg_two_ff <= nxt_cfg_two;
            if (reg_rd_en) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    localparam logic [tdc_pkg::TIMER_W-1:0] TIMER_LAST = tdc_pkg::TIMER_W'(SECOND_CYCLES - 1);
    localparam logic [tdc_pkg::TIMER_W-1:0] WINDOW_LEN = tdc_pkg::TIMER_W'(WINDOW_CYCLES);

    // one-second timer, window held for the first millisecond
    assign nxt_sec_cnt = (sec_cnt_ff >= TIMER_LAST) ? '0 : sec_cnt_ff + 1'b1;
    assign nxt_window = (nxt_sec_cnt < WINDOW_LEN);

    // free-running; the window only matters to channels in sampled mode
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sec_cnt_ff <= '0;
            window_ff <= 1'b0;
        end else if (clk_en) begin
            sec_cnt_ff <= nxt_sec_cnt;
            window_ff <= nxt_window;
        end
    end

    tdc_channel u_chan_one (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(intrusion_input_one),
        .cfg(cfg_one_ff),
        .osc_running(osc_running),
        .sample_window(window_ff),
        .clear_busy(clear_busy),
        .tamper_event(ev[0]),
        .flag(flag[0]),
        .pull_enable(pull_en_one),
        .pull_strong(pull_st_one)
    );

    // channel two, own pin and config; shares the sample window and clear timer with one
    tdc_channel u_chan_two (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(intrusion_input_two),
        .cfg(cfg_two_ff),
        .osc_running(osc_running),
        .sample_window(window_ff),
        .clear_busy(clear_busy),
        .tamper_event(ev[1]),
        .flag(flag[1]),
        .pull_enable(pull_en_two),
        .pull_strong(pull_st_two)
    );

    assign irq_allowed = ~on_battery | alarm_in_backup_enable;
    assign irq_fire = (|(ev & irq_en)) & irq_allowed;
    // clear by flags read, irq-enable written zero, or reset output
    assign irq_clear = rd_flags |
                       (wr_cfg_one & ~reg_wr_data[tdc_pkg::CFG_IRQ_ENABLE_BIT]) |
                       (wr_cfg_two & ~reg_wr_data[tdc_pkg::CFG_IRQ_ENABLE_BIT]) |
                       reset_req_ff;
    // a tamper in the clearing cycle still wins
    assign nxt_irq = irq_fire | (irq_ff & ~irq_clear);

    // external wipe needs both wipe and enable bits
    assign ext_fire = |(ev & ext_wipe & det_en);

    // freeze on first tamper, release when both enables zero
    assign nxt_freeze = (|ev) | (freeze_ff & (|det_en));

    // width code to seconds, sampled at the tamper
    assign clear_code = {clear_width_bit1, clear_width_bit0};
    assign clear_secs = (clear_code == 2'b00) ? tdc_pkg::CLEAR_S_CODE0 :
                        (clear_code == 2'b01) ? tdc_pkg::CLEAR_S_CODE1 :
                        (clear_code == 2'b10) ? tdc_pkg::CLEAR_S_CODE2 :
                        tdc_pkg::CLEAR_S_CODE3;
    // product stays under 2^32 for the sixteen second case
    assign clear_load = tdc_pkg::TIMER_W'(clear_secs) * tdc_pkg::TIMER_W'(SECOND_CYCLES);

    tdc_pulse_timer u_clear_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .load(ext_fire & ~clear_busy),
        .load_count(clear_load),
        .busy(clear_busy)
    );

    // interrupt, reset request, freeze and clear output registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
            reset_req_ff <= 1'b0;
            freeze_ff <= 1'b0;
            clear_out_ff <= 1'b0;
        end else if (clk_en) begin
            irq_ff <= nxt_irq;
            // one pulse into the shared reset stretcher
            reset_req_ff <= ext_fire & ~clear_busy;
            freeze_ff <= nxt_freeze;
            // clear output follows the width timer
            clear_out_ff <= clear_busy;
        end
    end

    // lock per channel until its enable is written zero
    assign nxt_lock = ((ev & int_wipe & det_en) | lock_ff) & det_en;

    // wipe sequencer sweeps every byte to zero
    always_comb begin
        nxt_wipe_state = wipe_state_ff;
        case (wipe_state_ff)
            tdc_pkg::WIPE_IDLE: begin
                if (|(ev & int_wipe & det_en)) begin
                    nxt_wipe_state = tdc_pkg::WIPE_SWEEP;
                end
            end
            tdc_pkg::WIPE_SWEEP: begin
                if (wipe_addr_ff == tdc_pkg::RAM_LAST_ADDR) begin
                    nxt_wipe_state = tdc_pkg::WIPE_DONE;
                end
            end
            tdc_pkg::WIPE_DONE: begin
                nxt_wipe_state = tdc_pkg::WIPE_IDLE;
            end
            default: begin
                nxt_wipe_state = tdc_pkg::WIPE_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wipe_state_ff <= tdc_pkg::WIPE_IDLE;
            wipe_addr_ff <= '0;
            lock_ff <= 2'b00;
        end else if (clk_en) begin
            wipe_state_ff <= nxt_wipe_state;
            lock_ff <= nxt_lock;
            if (wipe_state_ff == tdc_pkg::WIPE_SWEEP) begin
                wipe_addr_ff <= wipe_addr_ff + 1'b1;
            end else begin
                wipe_addr_ff <= '0;
            end
        end
    end

    // user access blocked while locked or while the wipe sequencer is not idle
    assign ram_blocked = (|lock_ff) | (wipe_state_ff != tdc_pkg::WIPE_IDLE);
    assign ram_write = ram_wr_en & ~ram_blocked;
    assign nxt_ram_rd = ram_blocked ? tdc_pkg::RAM_INVALID_DATA : ram_mem[ram_addr];

    // ram array, no reset: contents survive a system reset by design
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            if (wipe_state_ff == tdc_pkg::WIPE_SWEEP) begin
                ram_mem[wipe_addr_ff] <= 8'h00; // zero fill
            end else if (ram_write) begin
                ram_mem[ram_addr] <= ram_wr_data;
            end
        end
    end

    // ram read port and deselect output
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ram_rd_data_ff <= tdc_pkg::RAM_INVALID_DATA;
        end else if (clk_en & ram_rd_en) begin
            ram_rd_data_ff <= nxt_ram_rd;
        end
    end

    logic deselect_ff;
    logic [3:0] pull_ff;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            deselect_ff <= 1'b0;
            pull_ff <= 4'h0;
        end else if (clk_en) begin
            deselect_ff <= ram_blocked;
            pull_ff <= {pull_st_two, pull_st_one, pull_en_two, pull_en_one};
        end
    end

    assign reg_rd_data = rd_data_ff;
    assign ram_rd_data = ram_rd_data_ff;
    assign ram_deselect = deselect_ff;
    assign irq_active = irq_ff;
    assign external_clear_output = clear_out_ff;
    assign tamper_reset_req = reset_req_ff;
    assign clock_freeze = freeze_ff;
    assign pull_enable_one = pull_ff[0];
    assign pull_enable_two = pull_ff[1];
    assign pull_strong_one = pull_ff[2];
    assign pull_strong_two = pull_ff[3];
endmodule

// >>> rtl/tdc_pkg.sv
/*
 * Constants and types of the dual tamper block: offsets, field layout,
 * reset values, timing counts.
 * Assumes a 125 MHz system clock; long counts are overridable at the top.
 */
package tdc_pkg;

    // register offsets on the device register port
    localparam logic [7:0] ADDR_FLAGS = 8'h0F;
    localparam logic [7:0] ADDR_CFG_ONE = 8'h14;
    localparam logic [7:0] ADDR_CFG_TWO = 8'h15;

    // configuration field positions, msb first, matching tdc_cfg_t
    localparam int CFG_DETECT_ENABLE_BIT = 7;
    localparam int CFG_IRQ_ENABLE_BIT = 6;
    localparam int CFG_SWITCH_TYPE_BIT = 5;
    localparam int CFG_POLARITY_BIT = 4;
    localparam int CFG_SAMPLE_MODE_BIT = 3;
    localparam int CFG_PULL_STRENGTH_BIT = 2;
    localparam int CFG_INTERNAL_WIPE_BIT = 1;
    localparam int CFG_EXTERNAL_WIPE_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // flags register field positions
    localparam int FLAG_ONE_BIT = 0;
    localparam int FLAG_TWO_BIT = 1;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // answers for unmapped reads and deselected ram reads
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic [7:0] RAM_INVALID_DATA = 8'hFF;

    // internal user ram
    localparam int RAM_DEPTH = 128;
    localparam int RAM_AW = 7;
    localparam logic [6:0] RAM_LAST_ADDR = 7'h7F;

    // timing: figures in their own units, cycle counts derived
    localparam longint CLK_HZ = 125000000;
    localparam longint SECOND_S = 1;
    localparam longint SAMPLE_WINDOW_MS = 1;
    localparam int SECOND_CYCLES = int'(CLK_HZ * SECOND_S);
    localparam int WINDOW_CYCLES = int'((CLK_HZ * SAMPLE_WINDOW_MS) / 1000);

    // external clear width code to seconds
    localparam logic [4:0] CLEAR_S_CODE0 = 5'h01;
    localparam logic [4:0] CLEAR_S_CODE1 = 5'h04;
    localparam logic [4:0] CLEAR_S_CODE2 = 5'h08;
    localparam logic [4:0] CLEAR_S_CODE3 = 5'h10;

    localparam int TIMER_W = 32;

    typedef struct packed {
        logic detect_enable;
        logic irq_enable;
        logic switch_type;
        logic polarity;
        logic sample_mode;
        logic pull_strength;
        logic internal_wipe;
        logic external_wipe;
    } tdc_cfg_t;

    // internal ram wipe sequencer, one-hot
    typedef enum logic [2:0] {
        WIPE_IDLE = 3'b001,
        WIPE_SWEEP = 3'b010,
        WIPE_DONE = 3'b100
    } tdc_wipe_state_t;

endpackage

// >>> rtl/tdc_pulse_timer.sv
/*
 * Pulse timer: a load pulse gives a busy level of load_count enabled cycles.
 * Assumes load_count of at least one.
 */
`timescale 1ns/1ps
module tdc_pulse_timer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [tdc_pkg::TIMER_W-1:0] load_count,
    output logic busy
);
    logic [tdc_pkg::TIMER_W-1:0] cnt_ff;
    logic [tdc_pkg::TIMER_W-1:0] nxt_cnt;
    logic busy_ff;
    logic nxt_busy;

    // a reload while busy restarts the full width
    assign nxt_cnt = load ? load_count - 1'b1 :
                     (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    assign nxt_busy = load | (busy_ff & (cnt_ff != '0));
    assign busy = busy_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
        end else if (clk_en) begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
        end
    end
endmodule

// >>> rtl/tdc_channel.sv
/*
 * One tamper monitor: pin synchroniser, level compare, sampled or continuous
 * watching, pull control and the sticky tamper flag.
 * Assumes sample_window is a registered level.
 */
`timescale 1ns/1ps
module tdc_channel (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic pin_in,
    input tdc_pkg::tdc_cfg_t cfg,
    input wire logic osc_running,
    input wire logic sample_window,
    input wire logic clear_busy,
    output logic tamper_event,
    output logic flag,
    output logic pull_enable,
    output logic pull_strong
);
    logic sync1_ff;
    logic sync2_ff;
    logic flag_ff;
    logic pull_ff;
    logic pull_strong_ff;
    logic level_hit;
    logic sampled;
    logic nxt_pull;
    logic watching;
    logic blind;
    logic nxt_flag;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else if (clk_en) begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    assign level_hit = (sync2_ff == cfg.polarity);
    // sampled only when closed-type and oscillator runs
    assign sampled = ~cfg.switch_type & cfg.sample_mode & osc_running;
    // pull on in window, none for open-type, off once flagged
    assign nxt_pull = cfg.detect_enable & ~flag_ff & ~cfg.switch_type &
                      (~sampled | sample_window);
    // open-type watched always, closed-type while its pull is on
    assign watching = cfg.detect_enable & ~flag_ff & (cfg.switch_type | pull_ff);
    // high tamper on an external-wipe channel hidden while external clear runs
    assign blind = clear_busy & cfg.polarity & cfg.external_wipe;
    assign tamper_event = watching & level_hit & ~blind;
    // flag sticks until detect enable is zero
    assign nxt_flag = cfg.detect_enable & (flag_ff | tamper_event);

    assign flag = flag_ff;
    assign pull_enable = pull_ff;
    assign pull_strong = pull_strong_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_ff <= 1'b0;
            pull_ff <= 1'b0;
            pull_strong_ff <= 1'b0;
        end else if (clk_en) begin
            flag_ff <= nxt_flag;
            pull_ff <= nxt_pull;
            pull_strong_ff <= nxt_pull & cfg.pull_strength; // strength
        end
    end
endmodule

// >>> verif/tdc_switch_model.sv
/*
 * External tamper switch on one pin, either type.
 * Assumes pull_en comes from the block's pull output.
 */
`timescale 1ns/1ps
module tdc_switch_model (
    input wire logic closed,
    input wire logic normally_open,
    input wire logic polarity,
    input wire logic pull_en,
    output logic pin
);
    logic at_tamper;
    // switch position and pull
    // an undriven line drifts to the idle level, never a lucky match
    assign at_tamper = normally_open ? closed : (!closed && pull_en);
    assign pin = at_tamper ? polarity : !polarity;
endmodule

// >>> verif/tdc_top_properties.sv
/*
 * Port-level checks of the dual tamper block.
 * Assumes the bench keeps clk_en high and the clear width code steady.
 */
`timescale 1ns/1ps
module tdc_top_properties #(parameter int SECOND_CYCLES = 200) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic on_battery,
    input wire logic alarm_in_backup_enable,
    input wire logic clear_width_bit0,
    input wire logic clear_width_bit1,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic ram_rd_en,
    input wire logic [7:0] ram_rd_data,
    input wire logic ram_deselect,
    input wire logic irq_active,
    input wire logic external_clear_output,
    input wire logic tamper_reset_req,
    input wire logic clock_freeze
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    int hi_cnt_ff;
    int nxt_hi_cnt;
    int clear_secs;
    // length of the clear pulse so far, in cycles
    assign nxt_hi_cnt = external_clear_output ? hi_cnt_ff + 1 : 0;
    assign clear_secs = clear_width_bit1 ? (clear_width_bit0 ? 16 : 8) : (clear_width_bit0 ? 4 : 1);
    always_ff @(posedge sys_clk) begin
        hi_cnt_ff <= sys_rst ? 0 : nxt_hi_cnt;
    end
    flags_rd_irq_a: assert property (reg_rd_en && reg_addr == 8'h0F |=> !irq_active)
        else $error("irq survived a flags read");
    unmapped_zero_a: assert property (reg_rd_en && !(reg_addr inside {8'h0F, 8'h14, 8'h15})
        |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
    cfg_readback_a: assert property (reg_wr_en && reg_addr == 8'h14 ##2 reg_rd_en && reg_addr == 8'h14
        |=> reg_rd_data == $past(reg_wr_data, 3)) else $error("config readback wrong");
    ram_invalid_a: assert property (ram_rd_en && ram_deselect |=> ram_rd_data == 8'hFF)
        else $error("deselected ram returned data");
    clear_follows_a: assert property ($rose(external_clear_output) |-> $past(tamper_reset_req))
        else $error("clear output without reset request");
    clear_busy_a: assert property (external_clear_output |-> !tamper_reset_req)
        else $error("second fire during clear");
    reset_pulse_a: assert property (tamper_reset_req |=> !tamper_reset_req)
        else $error("reset request longer than one cycle");
    clear_width_a: assert property ($fell(external_clear_output) |-> hi_cnt_ff == clear_secs * SECOND_CYCLES)
        else $error("clear pulse width wrong");
    irq_stamp_a: assert property ($rose(irq_active) |-> clock_freeze)
        else $error("tamper irq without clock freeze");
    backup_mask_a: assert property (on_battery && !alarm_in_backup_enable ##1 on_battery
        && !alarm_in_backup_enable |-> !$rose(irq_active)) else $error("irq on battery");
endmodule

bind tdc_top tdc_top_properties #(.SECOND_CYCLES(SECOND_CYCLES)) u_props (.sys_clk, .sys_rst,
    .on_battery, .alarm_in_backup_enable, .clear_width_bit0, .clear_width_bit1, .reg_addr,
    .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .ram_rd_en, .ram_rd_data, .ram_deselect,
    .irq_active, .external_clear_output, .tamper_reset_req, .clock_freeze);

// >>> verif/test_dual_tamper_detect_control.sv
/*
 * Self-checking bench for the dual tamper block with two switch models.
 * Assumes short second and window counts of 200 and 10 cycles.
 */
`timescale 1ns/1ps
module test_dual_tamper_detect_control;
    logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    logic on_battery = 1'b0, osc_running = 1'b1, alarm_in_backup_enable = 1'b1;
    logic clear_width_bit0 = 1'b0, clear_width_bit1 = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, ram_wr_data = 8'h00;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, ram_wr_en = 1'b0, ram_rd_en = 1'b0;
    logic [6:0] ram_addr = 7'h00;
    logic [7:0] reg_rd_data, ram_rd_data, d;
    logic intrusion_input_one, intrusion_input_two, ram_deselect, irq_active, clock_freeze;
    logic external_clear_output, tamper_reset_req;
    logic pull_enable_one, pull_enable_two, pull_strong_one, pull_strong_two;
    logic [2:0] sw1 = 3'b100, sw2 = 3'b100; // closed, normally open, polarity
    int error_cnt = 0, checks_done = 0, n;
    tdc_switch_model sw_one (.closed(sw1[2]), .normally_open(sw1[1]), .polarity(sw1[0]),
        .pull_en(pull_enable_one), .pin(intrusion_input_one));
    tdc_switch_model sw_two (.closed(sw2[2]), .normally_open(sw2[1]), .polarity(sw2[0]),
        .pull_en(pull_enable_two), .pin(intrusion_input_two));
    tdc_top #(.SECOND_CYCLES(200), .WINDOW_CYCLES(10)) uut (.sys_clk, .sys_rst, .clk_en,
        .intrusion_input_one, .intrusion_input_two, .on_battery, .osc_running,
        .alarm_in_backup_enable, .clear_width_bit0, .clear_width_bit1, .reg_addr, .reg_wr_en,
        .reg_wr_data, .reg_rd_en, .reg_rd_data, .ram_addr, .ram_wr_en, .ram_wr_data, .ram_rd_en,
        .ram_rd_data, .ram_deselect, .irq_active, .external_clear_output, .tamper_reset_req,
        .clock_freeze, .pull_enable_one, .pull_enable_two, .pull_strong_one, .pull_strong_two);
    // free-running 125 MHz clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // one register access; read data after the edge
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        @(posedge sys_clk);
        {reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} <= {a, wd, wr, !wr};
        @(posedge sys_clk);
        {reg_wr_en, reg_rd_en} <= 2'b00;
        #1 d = reg_rd_data;
    endtask
    task automatic ram_acc(input logic wr, input logic [6:0] a, input logic [7:0] wd);
        @(posedge sys_clk);
        {ram_addr, ram_wr_data, ram_wr_en, ram_rd_en} <= {a, wd, wr, !wr};
        @(posedge sys_clk);
        {ram_wr_en, ram_rd_en} <= 2'b00;
        #1 d = ram_rd_data;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return irq_active;
            1: return external_clear_output;
            2: return ram_deselect;
            default: return pull_enable_one;
        endcase
    endfunction
    // bounded wait; a stuck output ends the run
    task automatic wait_sig(input int w, input logic v, input int lim);
        n = 0;
        while (pick(w) !== v && n < lim) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (pick(w) !== v) begin
            error_cnt++;
            $display("FAIL wait %0d expected %0h seen timeout", w, v);
            stop_test();
        end
    endtask
    task automatic s_reset();
        reg_acc(1'b0, 8'h14, 8'h00);
        chk("cfg_one", 8'h00, d);
        reg_acc(1'b0, 8'h15, 8'h00);
        chk("cfg_two", 8'h00, d);
        reg_acc(1'b1, 8'h0F, 8'hFF);
        reg_acc(1'b0, 8'h0F, 8'h00);
        chk("flags_ro", 8'h00, d);
        reg_acc(1'b1, 8'h14, 8'h5A);
        reg_acc(1'b0, 8'h14, 8'h00);
        chk("cfg_back", 8'h5A, d);
        reg_acc(1'b1, 8'h14, 8'h00);
        reg_acc(1'b0, 8'h20, 8'h00);
        chk("unmapped", 8'h00, d);
    endtask
    task automatic s_internal();
        ram_acc(1'b1, 7'h7F, 8'hA5);
        sw1 <= 3'b101;
        reg_acc(1'b1, 8'h14, 8'hD2);
        sw1 <= 3'b001;
        wait_sig(0, 1'b1, 20);
        chk("freeze", 1'b1, clock_freeze);
        reg_acc(1'b0, 8'h0F, 8'h00);
        chk("flags", 8'h01, d);
        chk("irq_clear", 1'b0, irq_active);
        ram_acc(1'b0, 7'h7F, 8'h00);
        chk("ram_locked", 8'hFF, d);
        sw1 <= 3'b101;
        reg_acc(1'b1, 8'h14, 8'h52);
        wait_sig(2, 1'b0, 200);
        ram_acc(1'b0, 7'h7F, 8'h00);
        chk("ram_wiped", 8'h00, d);
        reg_acc(1'b0, 8'h0F, 8'h00);
        chk("flag_clr", 8'h00, d);
        chk("unfreeze", 1'b0, clock_freeze);
    endtask
    task automatic s_external();
        sw2 <= 3'b010;
        clear_width_bit0 <= 1'b1;
        reg_acc(1'b1, 8'h15, 8'hE1);
        sw2 <= 3'b110;
        wait_sig(1, 1'b1, 20);
        wait_sig(1, 1'b0, 900);
        chk("clear_len", 800, n);
        sw2 <= 3'b010;
        reg_acc(1'b0, 8'h0F, 8'h00);
        chk("flags", 8'h02, d);
        reg_acc(1'b1, 8'h15, 8'h00);
    endtask
    task automatic s_sampled();
        sw1 <= 3'b100;
        on_battery <= 1'b1;
        alarm_in_backup_enable <= 1'b0;
        reg_acc(1'b1, 8'h14, 8'hCC);
        wait_sig(3, 1'b1, 250);
        chk("pull_strong", 1'b1, pull_strong_one);
        wait_sig(3, 1'b0, 20);
        chk("window", 10, n);
        sw1 <= 3'b000;
        wait_sig(3, 1'b1, 250);
        wait_sig(3, 1'b0, 20);
        reg_acc(1'b0, 8'h0F, 8'h00);
        chk("flags", 8'h01, d);
        chk("irq_bat", 1'b0, irq_active);
        sw1 <= 3'b100;
        reg_acc(1'b1, 8'h14, 8'h00);
        on_battery <= 1'b0;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        s_reset();
        s_internal();
        s_external();
        s_sampled();
        stop_test();
    end
endmodule
